// File: inc/cfs_pkg.sv
// cfs_pkg: constants shared by the file select command block
// assumes: byte-wide command fields, one clock domain
package cfs_pkg;
    // selection methods in the first parameter byte
    localparam logic [7:0] P1_BY_FID   = 8'h00;
    localparam logic [7:0] P1_CHILD_DF = 8'h01;
    localparam logic [7:0] P1_PARENT   = 8'h03;
    localparam logic [7:0] P1_BY_NAME  = 8'h04;
    localparam logic [7:0] P1_PATH_RT  = 8'h08;
    localparam logic [7:0] P1_PATH_CUR = 8'h09;
    // response control, second parameter byte bits 4..2 (b8 must be 0)
    localparam logic [2:0] P2_RC_FCP   = 3'h1;
    localparam logic [2:0] P2_RC_NONE  = 3'h3;
    localparam int         P2_SESS_LSB = 5;
    localparam logic [1:0] SESS_ACT    = 2'h0;
    localparam logic [1:0] SESS_TERM   = 2'h2;
    // response tags
    localparam logic [7:0] TAG_FCP     = 8'h62;
    localparam logic [7:0] TAG_SIZE    = 8'h80;
    localparam logic [7:0] TAG_TOTAL   = 8'h81;
    localparam logic [7:0] TAG_DESC    = 8'h82;
    localparam logic [7:0] TAG_FID     = 8'h83;
    localparam logic [7:0] TAG_NAME    = 8'h84;
    localparam logic [7:0] TAG_SFI     = 8'h88;
    localparam logic [7:0] TAG_LIFE    = 8'h8A;
    localparam logic [7:0] TAG_PROP    = 8'hA5;
    localparam logic [7:0] TAG_PIN     = 8'hC6;
    localparam logic [7:0] TAG_SEC0    = 8'h86;
    localparam logic [7:0] TAG_SEC1    = 8'h8B;
    localparam logic [7:0] TAG_SEC2    = 8'h8C;
    localparam logic [7:0] TAG_SEC3    = 8'hAB;
    localparam logic [7:0] LEN_LONG    = 8'h81;
    localparam logic [7:0] LEN_SIZE    = 8'h02;
    localparam logic [3:0] STEP_LAST   = 4'hF;
    localparam logic [15:0] FID_RESET  = 16'h0000;
    typedef enum logic [1:0] {
        KIND_EF = 2'b00, KIND_DF = 2'b01, KIND_ADF = 2'b10, KIND_ROOT = 2'b11
    } cfs_kind_e;
    typedef enum logic [2:0] {
        SC_CHILD  = 3'b000, SC_PARENT  = 3'b001, SC_SIBLING = 3'b010, SC_CHILD_DF = 3'b011,
        SC_NAME   = 3'b100, SC_PATH_RT = 3'b101, SC_PATH_CUR = 3'b110
    } cfs_scope_e;
    typedef enum logic [2:0] {
        ST_OK = 3'b000, ST_NOT_FOUND = 3'b001, ST_BAD_P1 = 3'b010, ST_BAD_P2 = 3'b011, ST_BAD_DATA = 3'b100
    } cfs_status_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_LOOK = 3'b001, S_WAIT = 3'b010, S_EMIT = 3'b011, S_DONE = 3'b100
    } cfs_state_e;
endpackage : cfs_pkg

// File: src/cfs_fifo.sv
// cfs_fifo: response byte buffer with valid/ready on both sides
// assumes: single clock, ce freezes all state
`timescale 1ns/1ps
`default_nettype none
module cfs_fifo #(
    parameter int W = 9,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q, rd_q;
    logic [AW:0]   cnt_q;
    logic          push, pop;
    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (push) begin
                wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : cfs_fifo
`default_nettype wire

// File: src/cfs_select.sv
// cfs_select: file select command interpreter, decodes parameters, drives a
// file store lookup in the mandated order and streams the control parameter template
// assumes: command fields and file attributes stay stable from cmd_valid to cmd_done
// What this block does
// - after a successful selection the record pointer is marked undefined
// - first parameter byte picks the method: fid, child, parent, name, path root, path current
// - bits 6..5 of second byte start or end an application session, name select only
// - method fid with no data makes the root the current directory
// - name select passes bits 1..0 on as occurrence control
// - fid search order: children of current, parent, children of parent
// - command data carries fid, name or path as the method needs
// - response starts with tag 62 then a one or two byte length
// - objects come in the fixed order for the file type
// - directory order: 82 83 (optional for an ADF) 84 optional A5 8A security C6 then optional 81
// - file order: 82 83 optional A5 8A security 80 optional 81 and 88
// - exactly one security object, tag 86 8B 8C or AB
// - template returned only when the exchange type expects response data
// - file size object is two bytes, high byte first
`timescale 1ns/1ps
`default_nettype none
module cfs_select #(
    parameter int        FIFO_DEPTH = 4,
    parameter logic [15:0] ROOT_FID = 16'h0001 // arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_p1,
    input  wire logic [7:0]  cmd_p2,
    input  wire logic        cmd_has_data,
    input  wire logic        cmd_expects_rsp,
    output logic             cmd_done,
    output logic [2:0]       cmd_status,
    output logic             lk_req,
    output logic [2:0]       lk_scope,
    output logic [1:0]       lk_occur,
    input  wire logic        lk_ack,
    input  wire logic        lk_hit,
    input  wire logic [15:0] lk_fid,
    input  wire logic [15:0] lk_parent,
    input  wire logic [1:0]  lk_kind,
    input  wire logic        attr_has_fid,
    input  wire logic        attr_has_prop,
    input  wire logic        attr_has_total,
    input  wire logic        attr_has_sfi,
    input  wire logic [1:0]  attr_sec_sel,
    input  wire logic [15:0] attr_file_size,
    input  wire logic [7:0]  attr_fcp_len,
    output logic [15:0]      cur_dir,
    output logic [15:0]      cur_file,
    output logic             rec_ptr_valid,
    output logic             sess_activate,
    output logic             sess_terminate,
    output logic             rsp_valid,
    input  wire logic        rsp_ready,
    output logic [8:0]       rsp_data
);
    cfs_pkg::cfs_state_e  state_q;
    cfs_pkg::cfs_scope_e  scope_q;
    logic [7:0]  p1_q, p2_q;
    logic        want_fcp_q, hit_q;
    logic [1:0]  kind_q;
    logic [15:0] fid_q, par_q;
    logic [3:0]  step_q;
    logic        push_ok, fifo_ready;
    logic        emit_en;
    logic [8:0]  emit_word;
    logic        is_dir;
    logic        p1_known, rc_fcp, rc_none;

    always_comb begin
        unique case (cmd_p1)
            cfs_pkg::P1_BY_FID, cfs_pkg::P1_CHILD_DF, cfs_pkg::P1_PARENT,
            cfs_pkg::P1_BY_NAME, cfs_pkg::P1_PATH_RT, cfs_pkg::P1_PATH_CUR: p1_known = 1'b1;
            default: p1_known = 1'b0;
        endcase
    end
    // bits 1..0 are left out of the compare: they carry occurrence or are don't care
    assign rc_fcp  = !cmd_p2[7] && cmd_p2[4:2] == cfs_pkg::P2_RC_FCP;
    assign rc_none = !cmd_p2[7] && cmd_p2[4:2] == cfs_pkg::P2_RC_NONE;
    assign is_dir  = (kind_q != cfs_pkg::KIND_EF);

    // command sequencing
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q    <= cfs_pkg::S_IDLE;
            scope_q    <= cfs_pkg::SC_CHILD;
            p1_q       <= '0;
            p2_q       <= '0;
            want_fcp_q <= 1'b0;
            cmd_status <= cfs_pkg::ST_OK;
            cmd_done   <= 1'b0;
            lk_req     <= 1'b0;
            lk_scope   <= '0;
            lk_occur   <= '0;
            hit_q      <= 1'b0;
        end else if (ce) begin
            cmd_done <= 1'b0;
            unique case (state_q)
                cfs_pkg::S_IDLE: begin
                    if (cmd_valid) begin
                        p1_q       <= cmd_p1;
                        p2_q       <= cmd_p2;
                        want_fcp_q <= rc_fcp && cmd_expects_rsp;
                        hit_q      <= 1'b0;
                        if (!p1_known) begin
                            cmd_status <= cfs_pkg::ST_BAD_P1;
                            state_q    <= cfs_pkg::S_DONE;
                        end else if (!rc_fcp && !rc_none) begin
                            cmd_status <= cfs_pkg::ST_BAD_P2;
                            state_q    <= cfs_pkg::S_DONE;
                        end else if (cmd_p1 == cfs_pkg::P1_BY_FID && !cmd_has_data) begin
                            cmd_status <= cfs_pkg::ST_OK;
                            want_fcp_q <= 1'b0;
                            state_q    <= cfs_pkg::S_DONE;
                        end else if (cmd_p1 != cfs_pkg::P1_PARENT && !cmd_has_data) begin
                            cmd_status <= cfs_pkg::ST_BAD_DATA;
                            state_q    <= cfs_pkg::S_DONE;
                        end else begin
                            unique case (cmd_p1)
                                cfs_pkg::P1_CHILD_DF: scope_q <= cfs_pkg::SC_CHILD_DF;
                                cfs_pkg::P1_PARENT:   scope_q <= cfs_pkg::SC_PARENT;
                                cfs_pkg::P1_BY_NAME:  scope_q <= cfs_pkg::SC_NAME;
                                cfs_pkg::P1_PATH_RT:  scope_q <= cfs_pkg::SC_PATH_RT;
                                cfs_pkg::P1_PATH_CUR: scope_q <= cfs_pkg::SC_PATH_CUR;
                                default:              scope_q <= cfs_pkg::SC_CHILD;
                            endcase
                            state_q <= cfs_pkg::S_LOOK;
                        end
                    end
                end
                cfs_pkg::S_LOOK: begin
                    lk_req   <= 1'b1;
                    lk_scope <= scope_q;
                    lk_occur <= (p1_q == cfs_pkg::P1_BY_NAME) ? p2_q[1:0] : 2'h0;
                    state_q  <= cfs_pkg::S_WAIT;
                end
                cfs_pkg::S_WAIT: begin
                    if (lk_ack) begin
                        lk_req <= 1'b0;
                        if (lk_hit) begin
                            hit_q      <= 1'b1;
                            cmd_status <= cfs_pkg::ST_OK;
                            state_q    <= want_fcp_q ? cfs_pkg::S_EMIT : cfs_pkg::S_DONE;
                        end else if (p1_q == cfs_pkg::P1_BY_FID && scope_q == cfs_pkg::SC_CHILD) begin
                            scope_q <= cfs_pkg::SC_PARENT;
                            state_q <= cfs_pkg::S_LOOK;
                        end else if (p1_q == cfs_pkg::P1_BY_FID && scope_q == cfs_pkg::SC_PARENT) begin
                            scope_q <= cfs_pkg::SC_SIBLING;
                            state_q <= cfs_pkg::S_LOOK;
                        end else begin
                            cmd_status <= cfs_pkg::ST_NOT_FOUND;
                            state_q    <= cfs_pkg::S_DONE;
                        end
                    end
                end
                cfs_pkg::S_EMIT: begin
                    if (step_q == cfs_pkg::STEP_LAST) begin
                        state_q <= cfs_pkg::S_DONE;
                    end
                end
                cfs_pkg::S_DONE: begin
                    cmd_done <= 1'b1;
                    state_q  <= cfs_pkg::S_IDLE;
                end
                default: state_q <= cfs_pkg::S_IDLE;
            endcase
        end
    end

    // selection state, touched only by a successful selection
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_dir        <= cfs_pkg::FID_RESET;
            cur_file       <= cfs_pkg::FID_RESET;
            rec_ptr_valid  <= 1'b0;
            sess_activate  <= 1'b0;
            sess_terminate <= 1'b0;
            kind_q         <= cfs_pkg::KIND_ROOT;
            fid_q          <= '0;
            par_q          <= '0;
        end else if (ce) begin
            sess_activate  <= 1'b0;
            sess_terminate <= 1'b0;
            if (state_q == cfs_pkg::S_IDLE && cmd_valid && p1_known && (rc_fcp || rc_none)
                && cmd_p1 == cfs_pkg::P1_BY_FID && !cmd_has_data) begin
                cur_dir       <= ROOT_FID;
                cur_file      <= ROOT_FID;
                kind_q        <= cfs_pkg::KIND_ROOT;
                rec_ptr_valid <= 1'b0;
            end
            if (state_q == cfs_pkg::S_WAIT && lk_ack && lk_hit) begin
                kind_q        <= lk_kind;
                fid_q         <= lk_fid;
                par_q         <= lk_parent;
                cur_file      <= lk_fid;
                cur_dir       <= (lk_kind == cfs_pkg::KIND_EF) ? lk_parent : lk_fid;
                rec_ptr_valid <= 1'b0;
                if (p1_q == cfs_pkg::P1_BY_NAME) begin
                    sess_activate  <= p2_q[cfs_pkg::P2_SESS_LSB +: 2] == cfs_pkg::SESS_ACT;
                    sess_terminate <= p2_q[cfs_pkg::P2_SESS_LSB +: 2] == cfs_pkg::SESS_TERM;
                end
            end
        end
    end

    // template walk: at most one step per cycle, an emitted object waits for fifo room, skipped objects cost one cycle each
    always_comb begin
        emit_en   = 1'b0;
        emit_word = '0;
        unique case (step_q)
            4'h0: begin emit_en = 1'b1; emit_word = {1'b0, cfs_pkg::TAG_FCP}; end
            4'h1: begin emit_en = attr_fcp_len[7]; emit_word = {1'b0, cfs_pkg::LEN_LONG}; end
            4'h2: begin emit_en = 1'b1; emit_word = {1'b0, attr_fcp_len}; end
            4'h3: begin emit_en = 1'b1; emit_word = {1'b1, cfs_pkg::TAG_DESC}; end
            4'h4: begin
                emit_en   = (kind_q != cfs_pkg::KIND_ADF) || attr_has_fid;
                emit_word = {1'b1, cfs_pkg::TAG_FID};
            end
            4'h5: begin emit_en = is_dir; emit_word = {1'b1, cfs_pkg::TAG_NAME}; end
            4'h6: begin emit_en = attr_has_prop; emit_word = {1'b1, cfs_pkg::TAG_PROP}; end
            4'h7: begin emit_en = 1'b1; emit_word = {1'b1, cfs_pkg::TAG_LIFE}; end
            4'h8: begin
                emit_en = 1'b1;
                unique case (attr_sec_sel)
                    2'h0: emit_word = {1'b1, cfs_pkg::TAG_SEC0};
                    2'h1: emit_word = {1'b1, cfs_pkg::TAG_SEC1};
                    2'h2: emit_word = {1'b1, cfs_pkg::TAG_SEC2};
                    2'h3: emit_word = {1'b1, cfs_pkg::TAG_SEC3};
                endcase
            end
            4'h9: begin
                emit_en   = 1'b1;
                emit_word = is_dir ? {1'b1, cfs_pkg::TAG_PIN} : {1'b0, cfs_pkg::TAG_SIZE};
            end
            4'hA: begin emit_en = !is_dir; emit_word = {1'b0, cfs_pkg::LEN_SIZE}; end
            4'hB: begin emit_en = !is_dir; emit_word = {1'b0, attr_file_size[15:8]}; end
            4'hC: begin emit_en = !is_dir; emit_word = {1'b0, attr_file_size[7:0]}; end
            4'hD: begin emit_en = attr_has_total; emit_word = {1'b1, cfs_pkg::TAG_TOTAL}; end
            4'hE: begin emit_en = !is_dir && attr_has_sfi; emit_word = {1'b1, cfs_pkg::TAG_SFI}; end
            default: begin emit_en = 1'b0; emit_word = '0; end
        endcase
    end
    assign push_ok = (state_q == cfs_pkg::S_EMIT) && emit_en && fifo_ready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            step_q <= '0;
        end else if (ce) begin
            if (state_q != cfs_pkg::S_EMIT) begin
                step_q <= '0;
            end else if (step_q != cfs_pkg::STEP_LAST && (!emit_en || fifo_ready)) begin
                step_q <= step_q + 4'h1;
            end
        end
    end

    cfs_fifo #(
        .W (9),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .in_valid  (push_ok),
        .in_ready  (fifo_ready),
        .in_data   (emit_word),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_data  (rsp_data)
    );
endmodule : cfs_select
`default_nettype wire

// File: test/cfs_select_sva.sv
// cfs_select_sva: port-level checks of the file select block
// assumes: bound into cfs_select, one clock, ce held high by the bench
`timescale 1ns/1ps
`default_nettype none
module cfs_select_sva #(
    parameter logic [15:0] ROOT_FID = 16'h0001
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic [7:0]  cmd_p1,
    input wire logic [7:0]  cmd_p2,
    input wire logic        cmd_has_data,
    input wire logic        cmd_done,
    input wire logic [2:0]  cmd_status,
    input wire logic        lk_req,
    input wire logic [2:0]  lk_scope,
    input wire logic [1:0]  lk_occur,
    input wire logic        lk_ack,
    input wire logic        lk_hit,
    input wire logic [15:0] cur_dir,
    input wire logic [15:0] cur_file,
    input wire logic        rec_ptr_valid,
    input wire logic        sess_terminate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_miss(logic [2:0] sc);
        lk_req && lk_ack && !lk_hit && lk_scope == sc;
    endsequence
    sequence s_next_req(logic [2:0] sc);
        ##[1:4] lk_req && lk_scope == sc;
    endsequence
    a_fid_parent_next: assert property (s_miss(cfs_pkg::SC_CHILD) |-> s_next_req(cfs_pkg::SC_PARENT))
        else $error("no parent lookup after child miss");
    a_fid_sibling_next: assert property (s_miss(cfs_pkg::SC_PARENT) ##0 cmd_p1 == cfs_pkg::P1_BY_FID
        |-> s_next_req(cfs_pkg::SC_SIBLING))
        else $error("no sibling lookup after parent miss");
    a_req_held: assert property (lk_req && !lk_ack |=> lk_req && $stable(lk_scope) && $stable(lk_occur))
        else $error("lookup request dropped before answer");
    a_done_pulse: assert property (cmd_done |=> !cmd_done)
        else $error("command done longer than one cycle");
    a_rec_undef: assert property (cmd_done && cmd_status == cfs_pkg::ST_OK |-> !rec_ptr_valid)
        else $error("record pointer valid after selection");
    a_occur_name: assert property (lk_req && lk_scope == cfs_pkg::SC_NAME |-> lk_occur == cmd_p2[1:0])
        else $error("occurrence control not passed on");
    a_occur_zero: assert property (lk_req && lk_scope != cfs_pkg::SC_NAME |-> lk_occur == 2'h0)
        else $error("occurrence control outside name select");
    a_bad_method: assert property (cmd_done && !(cmd_p1 inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h09})
        |-> cmd_status == cfs_pkg::ST_BAD_P1 && $stable(cur_dir) && $stable(cur_file))
        else $error("unknown method not refused");
    a_sess_term: assert property (sess_terminate |-> cmd_p1 == cfs_pkg::P1_BY_NAME
        && cmd_p2[6:5] == cfs_pkg::SESS_TERM)
        else $error("session end without name select");
    a_root_sel: assert property (cmd_done && cmd_status == cfs_pkg::ST_OK && cmd_p1 == cfs_pkg::P1_BY_FID
        && !cmd_has_data |-> ##[0:1] cur_dir == ROOT_FID)
        else $error("root not selected");
endmodule : cfs_select_sva
bind cfs_select cfs_select_sva #(.ROOT_FID(ROOT_FID)) cfs_select_sva_inst (.clk(clk), .arst_n(arst_n),
    .cmd_p1(cmd_p1), .cmd_p2(cmd_p2), .cmd_has_data(cmd_has_data), .cmd_done(cmd_done),
    .cmd_status(cmd_status), .lk_req(lk_req), .lk_scope(lk_scope), .lk_occur(lk_occur), .lk_ack(lk_ack),
    .lk_hit(lk_hit), .cur_dir(cur_dir), .cur_file(cur_file), .rec_ptr_valid(rec_ptr_valid),
    .sess_terminate(sess_terminate));
`default_nettype wire

// File: test/cfs_store.sv
// cfs_store: file store answering lookups, plus a response sink that may stall
// assumes: one hit scope per command, set by the bench
`timescale 1ns/1ps
`default_nettype none
module cfs_store (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        lk_req,
    input  wire logic [2:0]  lk_scope,
    input  wire logic [2:0]  hit_scope,
    input  wire logic [1:0]  kind,
    input  wire logic [15:0] fid,
    input  wire logic [1:0]  delay,
    input  wire logic        stall,
    output logic             lk_ack,
    output logic             lk_hit,
    output logic [15:0]      lk_fid,
    output logic [15:0]      lk_parent,
    output logic [1:0]       lk_kind,
    output logic             rsp_ready
);
    logic [1:0] cnt_q;
    logic       busy_q;
    logic       tgl_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q  <= 2'h0;
            busy_q <= 1'b0;
            lk_ack <= 1'b0;
            tgl_q  <= 1'b0;
        end else begin
            tgl_q  <= ~tgl_q;
            lk_ack <= 1'b0;
            if (!lk_req) begin
                cnt_q  <= 2'h0;
                busy_q <= 1'b0;
            end else if (!busy_q) begin
                if (cnt_q == delay) begin
                    lk_ack <= 1'b1;
                    busy_q <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end
    // outside the answer cycle the data toggles, so a late sample never looks right
    assign lk_hit    = lk_ack ? (lk_scope == hit_scope) : tgl_q;
    assign lk_fid    = lk_ack ? fid : {16{tgl_q}};
    assign lk_parent = lk_ack ? 16'h7F10 : {16{~tgl_q}};
    assign lk_kind   = lk_ack ? kind : {2{tgl_q}};
    assign rsp_ready = ~stall | tgl_q;
endmodule : cfs_store
`default_nettype wire

// File: test/cfs_select_tb_top.sv
// cfs_select_tb_top: directed scenarios for the file select block
// assumes: cfs_store stands for the file store and the response sink
`timescale 1ns/1ps
`default_nettype none
module cfs_select_tb_top;
    localparam logic [15:0] ROOT = 16'h0ABC;
    localparam logic [15:0] FID  = 16'h4D21;
    logic clk, arst_n, cmd_valid, cmd_has_data, cmd_expects_rsp, cmd_done, lk_req, lk_ack, lk_hit, req_d;
    logic attr_has_fid, attr_has_prop, attr_has_total, attr_has_sfi, rec_ptr_valid, stall;
    logic sess_activate, sess_terminate, rsp_valid, rsp_ready;
    logic [7:0]  cmd_p1, cmd_p2, attr_fcp_len;
    logic [2:0]  cmd_status, lk_scope, hit_scope;
    logic [1:0]  lk_occur, lk_kind, attr_sec_sel, kind;
    logic [15:0] lk_fid, lk_parent, attr_file_size, cur_dir, cur_file;
    logic [8:0]  rsp_data;
    logic [7:0]  got[$];
    logic [4:0]  scopes[$];
    int          fail_count, samples_checked, term_seen;
    cfs_select #(.ROOT_FID(ROOT)) cfs_select_inst (.clk, .arst_n, .ce(1'b1), .cmd_valid, .cmd_p1, .cmd_p2,
        .cmd_has_data, .cmd_expects_rsp, .cmd_done, .cmd_status, .lk_req, .lk_scope, .lk_occur, .lk_ack,
        .lk_hit, .lk_fid, .lk_parent, .lk_kind, .attr_has_fid, .attr_has_prop, .attr_has_total, .attr_has_sfi,
        .attr_sec_sel, .attr_file_size, .attr_fcp_len, .cur_dir, .cur_file, .rec_ptr_valid, .sess_activate,
        .sess_terminate, .rsp_valid, .rsp_ready, .rsp_data);
    cfs_store cfs_store_inst (.clk, .arst_n, .lk_req, .lk_scope, .hit_scope, .kind, .fid(FID),
        .delay(2'h2), .stall, .lk_ack, .lk_hit, .lk_fid, .lk_parent, .lk_kind, .rsp_ready);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rsp_valid && rsp_ready) got.push_back(rsp_data[7:0]);
        if (lk_req && !req_d) scopes.push_back({lk_occur, lk_scope});
        if (sess_terminate) term_seen++;
        if (sess_activate) term_seen += 16;
        req_d <= lk_req;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic chk_rsp(input logic [7:0] e[$]);
        chk("rsp length", 16'(got.size()), 16'(e.size()));
        foreach (e[i]) if (i < got.size()) chk("rsp byte", 16'(got[i]), 16'(e[i]));
    endtask : chk_rsp
    task automatic run(input logic [7:0] p1, input logic [7:0] p2, input logic dat, input logic er);
        int n;
        @(negedge clk);
        got.delete();
        scopes.delete();
        term_seen = 0;
        cmd_p1 = p1;
        cmd_p2 = p2;
        cmd_has_data = dat;
        cmd_expects_rsp = er;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        n = 0;
        while (cmd_done !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n == 300) chk("command done", 16'h0, 16'h1);
        repeat (10) @(negedge clk);
    endtask : run
    task automatic set_attr(input logic [3:0] f, input logic [1:0] sec, input logic [7:0] len);
        {attr_has_fid, attr_has_prop, attr_has_total, attr_has_sfi} = f;
        attr_sec_sel = sec;
        attr_fcp_len = len;
    endtask : set_attr
    task automatic t_ef_full;
        hit_scope = 3'h0;
        kind = 2'h0;
        stall = 1'b1;
        set_attr(4'hF, 2'h3, 8'h20);
        run(8'h00, 8'h04, 1'b1, 1'b1);
        chk("status", 16'(cmd_status), 16'h0);
        chk("file", cur_file, FID);
        chk("record pointer", 16'(rec_ptr_valid), 16'h0);
        chk_rsp('{8'h62, 8'h20, 8'h82, 8'h83, 8'hA5, 8'h8A, 8'hAB, 8'h80, 8'h02, 8'hA5, 8'h5A, 8'h81, 8'h88});
        $display("test ef_full done");
    endtask : t_ef_full
    task automatic t_search;
        hit_scope = 3'h2;
        stall = 1'b0;
        run(8'h00, 8'h04, 1'b1, 1'b0);
        chk("lookups", 16'(scopes.size()), 16'h3);
        foreach (scopes[i]) chk("scope", 16'(scopes[i]), 16'(i));
        chk("no template", 16'(got.size()), 16'h0);
        $display("test search done");
    endtask : t_search
    task automatic t_dir;
        hit_scope = 3'h3;
        kind = 2'h1;
        stall = 1'b1;
        set_attr(4'hB, 2'h0, 8'h90);
        run(8'h01, 8'h04, 1'b1, 1'b1);
        chk("dir", cur_dir, FID);
        chk_rsp('{8'h62, 8'h81, 8'h90, 8'h82, 8'h83, 8'h84, 8'h8A, 8'h86, 8'hC6, 8'h81});
        $display("test dir done");
    endtask : t_dir
    task automatic t_name;
        hit_scope = 3'h4;
        kind = 2'h2;
        set_attr(4'h4, 2'h1, 8'h10);
        run(8'h04, 8'h46, 1'b1, 1'b1);
        chk("name lookup", 16'(scopes[0]), 16'h14);
        chk("session end", 16'(term_seen), 16'h1);
        chk_rsp('{8'h62, 8'h10, 8'h82, 8'h84, 8'hA5, 8'h8A, 8'h8B, 8'hC6});
        run(8'h04, 8'h04, 1'b1, 1'b0);
        chk("session start", 16'(term_seen), 16'h10);
        $display("test name done");
    endtask : t_name
    task automatic t_methods;
        logic [7:0] p1s[3] = '{8'h03, 8'h08, 8'h09};
        logic [2:0] scs[3] = '{3'h1, 3'h5, 3'h6};
        foreach (p1s[i]) begin
            hit_scope = scs[i];
            run(p1s[i], 8'h0C, 1'b1, 1'b0);
            chk("method scope", 16'(scopes[0]), 16'(scs[i]));
        end
        $display("test methods done");
    endtask : t_methods
    task automatic t_refuse;
        logic [15:0] d;
        d = cur_dir;
        run(8'h02, 8'h04, 1'b1, 1'b1);
        chk("bad method", 16'(cmd_status), 16'h2);
        chk("dir kept", cur_dir, d);
        chk("no lookup", 16'(scopes.size()), 16'h0);
        run(8'h00, 8'h00, 1'b1, 1'b1);
        chk("bad control", 16'(cmd_status), 16'h3);
        run(8'h00, 8'h0C, 1'b0, 1'b1);
        chk("root status", 16'(cmd_status), 16'h0);
        chk("root dir", cur_dir, ROOT);
        chk("root silent", 16'(got.size()), 16'h0);
        $display("test refuse done");
    endtask : t_refuse
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        {cmd_valid, cmd_has_data, cmd_expects_rsp, stall, arst_n} = 5'h0;
        {cmd_p1, cmd_p2, hit_scope, kind} = 21'h0;
        attr_file_size = 16'hA55A;
        set_attr(4'h0, 2'h0, 8'h00);
        repeat (3) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        t_ef_full();
        t_search();
        t_dir();
        t_name();
        t_methods();
        t_refuse();
        results();
    end
    // the whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule : cfs_select_tb_top
`default_nettype wire
